//--- design/imu_field_pkg.sv
// Constants, state codes and mode codes shared by the datagram field formatter.
// Assumes one 20 MHz clock and an active-low asynchronous reset everywhere.
package imu_field_pkg;
    // ********************************************
    // Widths and counts
    // ********************************************
    localparam int DATA_W = 24;
    localparam int TEMP_W = 16;
    localparam int BYTE_W = 8;
    localparam int AXES = 6;
    localparam int GYRO_AXES = 3;
    localparam int ACC_AXES = 3;
    localparam int FIFO_DEPTH = 4;
    // ********************************************
    // Timing
    // ********************************************
    localparam int CLOCK_PERIOD_NS = 50;
    localparam int MICROSECOND_NS = 1000;
    localparam int US_CYCLES = MICROSECOND_NS / CLOCK_PERIOD_NS;
    // ********************************************
    // Scaling and reset values
    // ********************************************
    localparam int VEL_SCALE_FRAC = 16;
    localparam int VEL_SCALE_DEFAULT = 2571;
    localparam logic [DATA_W-1:0] FILTERED_ONE = 24'h400000;
    localparam logic [DATA_W-1:0] PULSE_MAX = 24'h7FFFFF;
    localparam logic [DATA_W-1:0] ACCUM_RESET = 24'h000000;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    // ********************************************
    // Frame layout, bit offsets from the frame LSB
    // ********************************************
    localparam int FRAME_BITS = 296;
    localparam logic [5:0] FRAME_BYTES = 6'h25;
    localparam logic [5:0] TEMP_BYTES = 6'h0C;
    localparam int ACC_POS = 152;
    localparam int PULSE_POS = 128;
    localparam int COUNT_POS = 112;
    // ********************************************
    // Modes and states
    // ********************************************
    typedef enum logic [1:0] {ACC_G = 2'h0, ACC_INC = 2'h1, ACC_INT = 2'h2} accel_unit_t;
    typedef enum logic [1:0] {PULSE_SINCE_0 = 2'h0, PULSE_SINCE_1 = 2'h1, PULSE_FILT = 2'h2} pulse_unit_t;
    typedef enum logic [3:0] {S_IDLE = 4'h1, S_TRIM = 4'h2, S_CONV = 4'h4, S_SEND = 4'h8} fmt_state_t;
endpackage : imu_field_pkg

//--- design/byte_fifo.sv
// Small synchronous FIFO with valid/ready on both sides.
// Assumes both sides run on the same clock; full and empty are exact.
module byte_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 4
) (
    input wire logic i_clock,
    input wire logic i_nrst,
    input wire logic i_valid,
    output logic o_ready,
    input wire logic [WIDTH-1:0] i_data,
    output logic o_valid,
    input wire logic i_ready,
    output logic [WIDTH-1:0] o_data
);
    localparam int PTR_W = $clog2(DEPTH);
    localparam int CNT_W = $clog2(DEPTH + 1);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
    logic [CNT_W-1:0] count;
    logic push;
    logic pop;

    // Honest flags: full stalls the writer, empty hides stale data.
    assign o_ready = (count != CNT_W'(DEPTH));
    assign o_valid = (count != '0);
    assign o_data = mem[rd_ptr];
    assign push = i_valid && o_ready;
    assign pop = o_valid && i_ready;

    // Storage needs no reset; only entries below count are ever read.
    always_ff @(posedge i_clock) begin
        if (push) begin
            mem[wr_ptr] <= i_data;
        end
    end

    // Pointers wrap at DEPTH, which need not be a power of two.
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
            count <= count + CNT_W'(push) - CNT_W'(pop);
        end
    end
endmodule : byte_fifo

//--- design/axis_bias_trim.sv
// Per-axis bias correction store and post-compensation adder.
// Assumes the caller gates i_load with the adjustment modes.
module axis_bias_trim #(
    parameter int AXES = 6,
    parameter int DATA_W = 24
) (
    input wire logic i_clock,
    input wire logic i_nrst,
    input wire logic i_load,
    input wire logic [$clog2(AXES)-1:0] i_axis,
    input wire logic [DATA_W-1:0] i_value,
    input wire logic i_capture,
    input wire logic [AXES*DATA_W-1:0] i_data,
    output logic [AXES*DATA_W-1:0] o_data,
    output logic [AXES*DATA_W-1:0] o_bias
);
    for (genvar k = 0; k < AXES; k++) begin : g_axis
        logic [DATA_W-1:0] axis_bias_correction;

        // Each axis owns its correction; a load touches one axis only.
        always_ff @(posedge i_clock or negedge i_nrst) begin
            if (!i_nrst) begin
                axis_bias_correction <= '0;
            end else if (i_load && (i_axis == ($clog2(AXES))'(k))) begin
                axis_bias_correction <= i_value;
            end
        end

        // Added in sensor units, ahead of any velocity conversion.
        always_ff @(posedge i_clock or negedge i_nrst) begin
            if (!i_nrst) begin
                o_data[k*DATA_W +: DATA_W] <= '0;
            end else if (i_capture) begin
                o_data[k*DATA_W +: DATA_W] <= i_data[k*DATA_W +: DATA_W] + axis_bias_correction;
            end
        end

        assign o_bias[k*DATA_W +: DATA_W] = axis_bias_correction;
    end
endmodule : axis_bias_trim

//--- design/imu_datagram_field_formatter.sv
// Forms the measurement fields of one output datagram and streams them as bytes.
// Assumes the sample engine supplies compensated data, temperatures and latency
// on the same clock, and that the pulse pin is asynchronous.
module imu_datagram_field_formatter #(
    parameter int DATA_W = imu_field_pkg::DATA_W,
    parameter int TEMP_W = imu_field_pkg::TEMP_W,
    parameter int AXES = imu_field_pkg::AXES,
    parameter int FIFO_DEPTH = imu_field_pkg::FIFO_DEPTH,
    parameter int VEL_SCALE = imu_field_pkg::VEL_SCALE_DEFAULT
) (
    input wire logic i_clock,
    input wire logic i_nrst,
    input wire logic i_sample_valid,
    output logic o_sample_ready,
    input wire logic [AXES*DATA_W-1:0] i_comp_data,
    input wire logic [AXES*TEMP_W-1:0] i_temp,
    input wire logic [15:0] i_latency,
    input wire logic [1:0] i_accel_unit,
    input wire logic [1:0] i_pulse_unit,
    input wire logic i_with_temp,
    input wire logic i_count_two_bytes,
    input wire logic i_pps_pin,
    input wire logic [DATA_W-1:0] i_pps_filtered,
    input wire logic i_trim_mode,
    input wire logic i_service_mode,
    input wire logic i_bias_load,
    input wire logic [$clog2(AXES)-1:0] i_bias_axis,
    input wire logic [DATA_W-1:0] i_bias_value,
    output logic [7:0] o_byte,
    output logic o_byte_last,
    output logic o_byte_valid,
    input wire logic i_byte_ready
);
    localparam int GA = imu_field_pkg::GYRO_AXES;
    localparam int NA = imu_field_pkg::ACC_AXES;
    localparam int FB = imu_field_pkg::FRAME_BITS;
    localparam int FR = imu_field_pkg::VEL_SCALE_FRAC;
    localparam int UW = $clog2(imu_field_pkg::US_CYCLES);

    imu_field_pkg::fmt_state_t state;
    logic accept;
    logic [AXES*DATA_W-1:0] trimmed;
    logic [AXES*DATA_W-1:0] bias_now;
    logic [DATA_W-1:0] accel_field [NA];
    logic [DATA_W-1:0] vel_accum [NA];
    logic [DATA_W-1:0] inc_vel [NA];
    logic [AXES*TEMP_W-1:0] temp_hold;
    logic [15:0] latency_hold;
    logic [15:0] sample_count;
    logic [15:0] count_hold;
    logic [DATA_W-1:0] pulse_hold;
    logic pps_meta;
    logic pps_sync;
    logic pps_prev;
    logic pulse_restart;
    logic [UW-1:0] us_div;
    logic [DATA_W-1:0] pulse_timer;
    logic [FB-1:0] shift;
    logic [5:0] left;
    logic fifo_in_ready;
    logic fifo_in_valid;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [8:0] fifo_out_data;
    logic push;

    // Filtered value is kept inside [0, 1] whatever the filter delivers.
    function automatic logic [DATA_W-1:0] clamp_unit(input logic [DATA_W-1:0] v);
        if (v[DATA_W-1]) begin
            return '0;
        end else if (v > imu_field_pkg::FILTERED_ONE) begin
            return imu_field_pkg::FILTERED_ONE;
        end
        return v;
    endfunction : clamp_unit

    // ********************************************
    // Sample intake and bias correction
    // ********************************************
    assign accept = i_sample_valid && o_sample_ready;

    axis_bias_trim #(
        .AXES(AXES),
        .DATA_W(DATA_W)
    ) u_trim (
        .i_clock(i_clock),
        .i_nrst(i_nrst),
        .i_load(i_bias_load && (i_trim_mode || i_service_mode)),
        .i_axis(i_bias_axis),
        .i_value(i_bias_value),
        .i_capture(accept),
        .i_data(i_comp_data),
        .o_data(trimmed),
        .o_bias(bias_now)
    );

    // Side fields are frozen at intake so the frame is one consistent sample.
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            temp_hold <= '0;
            latency_hold <= '0;
            count_hold <= imu_field_pkg::COUNT_RESET;
            sample_count <= imu_field_pkg::COUNT_RESET;
            pulse_hold <= '0;
        end else if (accept) begin
            temp_hold <= i_temp;
            latency_hold <= i_latency;
            count_hold <= sample_count;
            sample_count <= sample_count + 16'h0001;
            pulse_hold <= (i_pulse_unit == imu_field_pkg::PULSE_FILT) ?
                clamp_unit(i_pps_filtered) : pulse_timer;
        end
    end

    // ********************************************
    // Pulse pin timing
    // ********************************************
    // The pin is asynchronous, so only the second and third stages are looked at.
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            pps_meta <= 1'b0;
            pps_sync <= 1'b0;
            pps_prev <= 1'b0;
        end else begin
            pps_meta <= i_pps_pin;
            pps_sync <= pps_meta;
            pps_prev <= pps_sync;
        end
    end

    // Restart when the pin arrives at the watched level.
    assign pulse_restart = (pps_sync != pps_prev) &&
        (pps_sync == (i_pulse_unit == imu_field_pkg::PULSE_SINCE_1));

    // Microsecond count; it holds at the top rather than turning negative.
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            us_div <= '0;
            pulse_timer <= '0;
        end else if (pulse_restart) begin
            us_div <= '0;
            pulse_timer <= '0;
        end else if (us_div == UW'(imu_field_pkg::US_CYCLES - 1)) begin
            us_div <= '0;
            if (pulse_timer != imu_field_pkg::PULSE_MAX) begin
                pulse_timer <= pulse_timer + 24'h000001;
            end
        end else begin
            us_div <= us_div + 1'b1;
        end
    end

    // ********************************************
    // Velocity conversion and integration
    // ********************************************
    for (genvar k = 0; k < NA; k++) begin : g_acc
        logic signed [DATA_W+16:0] prod;

        // The correction is already in g here, so it scales with the data.
        assign prod = $signed(trimmed[(GA+k)*DATA_W +: DATA_W]) * $signed(17'(VEL_SCALE));
        assign inc_vel[k] = prod[FR +: DATA_W];

        // Integration runs every sample in every mode, from reset onward.
        always_ff @(posedge i_clock or negedge i_nrst) begin
            if (!i_nrst) begin
                vel_accum[k] <= imu_field_pkg::ACCUM_RESET;
                accel_field[k] <= '0;
            end else if (state == imu_field_pkg::S_TRIM) begin
                vel_accum[k] <= vel_accum[k] + inc_vel[k];
                unique case (i_accel_unit)
                    imu_field_pkg::ACC_INC: accel_field[k] <= inc_vel[k];
                    imu_field_pkg::ACC_INT: accel_field[k] <= vel_accum[k] + inc_vel[k];
                    default: accel_field[k] <= trimmed[(GA+k)*DATA_W +: DATA_W];
                endcase
            end
        end
    end

    // ********************************************
    // Frame sequencing
    // ********************************************
    assign fifo_in_valid = (state == imu_field_pkg::S_SEND);
    assign push = fifo_in_valid && fifo_in_ready;

    // Sequence: intake, convert, pack, then bytes until the last is queued.
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            state <= imu_field_pkg::S_IDLE;
            o_sample_ready <= 1'b1;
        end else begin
            unique case (state)
                imu_field_pkg::S_IDLE: begin
                    if (accept) begin
                        state <= imu_field_pkg::S_TRIM;
                        o_sample_ready <= 1'b0;
                    end
                end
                imu_field_pkg::S_TRIM: state <= imu_field_pkg::S_CONV;
                imu_field_pkg::S_CONV: state <= imu_field_pkg::S_SEND;
                imu_field_pkg::S_SEND: begin
                    if (push && (left == 6'h01)) begin
                        state <= imu_field_pkg::S_IDLE;
                        o_sample_ready <= 1'b1;
                    end
                end
            endcase
        end
    end

    // Temperatures sit last so dropping them only shortens the frame.
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            shift <= '0;
            left <= '0;
        end else if (state == imu_field_pkg::S_CONV) begin
            if (i_count_two_bytes) begin
                shift <= {trimmed[GA*DATA_W-1:0], accel_field[0], accel_field[1], accel_field[2],
                    pulse_hold, count_hold, latency_hold, temp_hold};
            end else begin
                shift <= {trimmed[GA*DATA_W-1:0], accel_field[0], accel_field[1], accel_field[2],
                    pulse_hold, count_hold[7:0], latency_hold, temp_hold, 8'h00};
            end
            left <= imu_field_pkg::FRAME_BYTES - (i_count_two_bytes ? 6'h00 : 6'h01) -
                (i_with_temp ? 6'h00 : imu_field_pkg::TEMP_BYTES);
        end else if (push) begin
            shift <= {shift[FB-9:0], 8'h00};
            left <= left - 6'h01;
        end
    end

    // ********************************************
    // Output buffer and register
    // ********************************************
    // The FIFO absorbs host stalls; a full FIFO holds the sequencer in S_SEND.
    byte_fifo #(
        .WIDTH(9),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .i_clock(i_clock),
        .i_nrst(i_nrst),
        .i_valid(fifo_in_valid),
        .o_ready(fifo_in_ready),
        .i_data({left == 6'h01, shift[FB-1 -: 8]}),
        .o_valid(fifo_out_valid),
        .i_ready(fifo_out_ready),
        .o_data(fifo_out_data)
    );

    assign fifo_out_ready = !o_byte_valid || i_byte_ready;

    // Registered output stage so every port comes from a flip-flop.
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            o_byte <= 8'h00;
            o_byte_last <= 1'b0;
            o_byte_valid <= 1'b0;
        end else if (fifo_out_ready) begin
            o_byte_valid <= fifo_out_valid;
            o_byte <= fifo_out_data[7:0];
            o_byte_last <= fifo_out_data[8];
        end
    end

    // ********************************************
    // Assertions
    // ********************************************
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_nrst);

    // Arithmetic checks: accum_wrap_a, inc_field_a, us_tick_a and bias_sum_a compare a result with values one cycle earlier.
    accum_wrap_a: assert property ((state == imu_field_pkg::S_TRIM) |=>
        vel_accum[0] == 24'($past(vel_accum[0]) + $past(inc_vel[0])))
        else $error("velocity accumulator did not add the increment");
    integ_field_a: assert property ((state == imu_field_pkg::S_CONV && i_accel_unit == 2'h2) |->
        accel_field[1] == vel_accum[1])
        else $error("integrated field differs from accumulator");
    inc_field_a: assert property (($past(state) == imu_field_pkg::S_TRIM && i_accel_unit == 2'h1
        && $stable(i_accel_unit)) |-> accel_field[2] == $past(inc_vel[2]))
        else $error("incremental field differs from conversion");
    frame_length_a: assert property ((state == imu_field_pkg::S_CONV && i_with_temp && i_count_two_bytes)
        |=> left == imu_field_pkg::FRAME_BYTES)
        else $error("full frame length wrong");
    counter_order_a: assert property ((state == imu_field_pkg::S_CONV && i_count_two_bytes) |=>
        shift[imu_field_pkg::COUNT_POS +: 16] == count_hold)
        else $error("counter bytes misplaced");
    filtered_range_a: assert property ((state == imu_field_pkg::S_CONV && i_pulse_unit == 2'h2) |->
        !pulse_hold[DATA_W-1] && pulse_hold <= imu_field_pkg::FILTERED_ONE)
        else $error("filtered pulse out of range");
    us_tick_a: assert property ((us_div == UW'(imu_field_pkg::US_CYCLES - 1) && !pulse_restart
        && pulse_timer != imu_field_pkg::PULSE_MAX) |=> pulse_timer == 24'($past(pulse_timer) + 1))
        else $error("microsecond count did not advance");
    bias_sum_a: assert property (accept |=> trimmed[0 +: DATA_W] ==
        24'($past(i_comp_data[0 +: DATA_W]) + $past(bias_now[0 +: DATA_W])))
        else $error("axis correction not added");
    frame_end_a: assert property ((push && left == 6'h01) |=>
        o_sample_ready ##0 state == imu_field_pkg::S_IDLE)
        else $error("frame did not close after last byte");
    // A restart must clear the count, or the field would carry time from before the edge.
    pulse_zero_a: assert property (pulse_restart |=> pulse_timer == '0)
        else $error("pulse count not cleared on restart");

    // ********************************************
    // Handshake and layout checks
    // ********************************************
    // Intake closes at once, so an offer during a frame can never start a second one.
    intake_close_a: assert property (accept |=> !o_sample_ready && state == imu_field_pkg::S_TRIM)
        else $error("sample intake did not close");
    // A stalled host must keep seeing the same byte, or a field would lose a byte.
    byte_hold_a: assert property ((o_byte_valid && !i_byte_ready) |=>
        o_byte_valid && $stable(o_byte) && $stable(o_byte_last))
        else $error("output byte changed while stalled");

    // The packed word is checked on the first cycle after packing, before any byte leaves.
    accel_place_a: assert property ((state == imu_field_pkg::S_CONV) |=>
        shift[imu_field_pkg::ACC_POS +: DATA_W] == accel_field[2])
        else $error("last accel field misplaced");
    pulse_place_a: assert property ((state == imu_field_pkg::S_CONV) |=>
        shift[imu_field_pkg::PULSE_POS +: DATA_W] == pulse_hold)
        else $error("pulse field misplaced");
    short_count_a: assert property ((state == imu_field_pkg::S_CONV && !i_count_two_bytes) |=>
        shift[imu_field_pkg::COUNT_POS + imu_field_pkg::BYTE_W +: imu_field_pkg::BYTE_W] == count_hold[7:0])
        else $error("one-byte counter misplaced");
    temp_words_a: assert property ((state == imu_field_pkg::S_CONV && i_count_two_bytes) |=>
        shift[0 +: AXES*TEMP_W] == temp_hold)
        else $error("temperature words misplaced");
    latency_word_a: assert property ((state == imu_field_pkg::S_CONV && !i_count_two_bytes) |=>
        shift[AXES*TEMP_W + imu_field_pkg::BYTE_W +: 16] == latency_hold)
        else $error("latency word misplaced");

    // A load inside an adjustment mode lands on its own axis; one outside the modes is dropped.
    bias_axis_a: assert property ((i_bias_load && (i_trim_mode || i_service_mode)
        && int'(i_bias_axis) < AXES) |=> bias_now[$past(i_bias_axis)*DATA_W +: DATA_W] == $past(i_bias_value))
        else $error("axis correction not loaded");
    bias_refuse_a: assert property ((i_bias_load && !i_trim_mode && !i_service_mode) |=> $stable(bias_now))
        else $error("correction changed outside adjustment modes");

    // Covers for the main scenarios: integration, short frames, restarts, stalls and refused loads.
    integ_frame_c: cover property ((state == imu_field_pkg::S_CONV && i_accel_unit == 2'h2) ##[1:60] o_byte_last);
    short_frame_c: cover property (state == imu_field_pkg::S_CONV && !i_with_temp && !i_count_two_bytes);
    pulse_restart_c: cover property (pulse_restart ##1 accept);
    stall_full_c: cover property (fifo_in_valid && !fifo_in_ready);
    refused_load_c: cover property (i_bias_load && !i_trim_mode && !i_service_mode);
endmodule : imu_datagram_field_formatter

//--- verification/host_sink.sv
// Host-side model that takes the formatter's byte stream into a queue.
// Assumes one clock; ready changes only at the falling edge.
module host_sink (
    input wire logic i_clock,
    input wire logic i_nrst,
    input wire logic [7:0] i_byte,
    input wire logic i_byte_last,
    input wire logic i_byte_valid,
    output logic o_byte_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [8:0] rx_q[$];
    int seed = 32'h3f4358b9;
    // Ready drops about one cycle in four, so the FIFO fills and the sequencer must stall.
    initial begin
        o_byte_ready = 1'b0;
        forever begin
            @(negedge i_clock);
            o_byte_ready = i_nrst && (($random(seed) & 3) != 0);
        end
    end
    // A byte is taken only at an edge where valid and ready are both high.
    always @(posedge i_clock) begin
        if (i_nrst && i_byte_valid && o_byte_ready) begin
            rx_q.push_back({i_byte_last, i_byte});
        end
    end
endmodule : host_sink

//--- verification/imu_datagram_field_formatter_tb.sv
// Testbench for the datagram field formatter, with a queue model of each frame.
// Assumes host_sink collects the bytes; inputs change at the falling edge.
module imu_datagram_field_formatter_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int VS = imu_field_pkg::VEL_SCALE_DEFAULT;
    logic i_clock, i_nrst, i_sample_valid, o_sample_ready, i_with_temp, i_count_two_bytes, i_pps_pin;
    logic i_trim_mode, i_service_mode, i_bias_load, o_byte_last, o_byte_valid, i_byte_ready;
    logic [143:0] i_comp_data;
    logic [95:0] i_temp;
    logic [15:0] i_latency;
    logic [1:0] i_accel_unit, i_pulse_unit;
    logic [23:0] i_pps_filtered, i_bias_value;
    logic [2:0] i_bias_axis;
    logic [7:0] o_byte;
    logic [23:0] bias[6];
    logic [23:0] acc[3];
    logic [15:0] cnt;
    logic [7:0] exp_q[$];
    int n_fail, total_checks;
    int seed = 32'h3f4358b9;

    imu_datagram_field_formatter #(.VEL_SCALE(VS)) dut_u (.i_clock, .i_nrst, .i_sample_valid, .o_sample_ready,
        .i_comp_data, .i_temp, .i_latency, .i_accel_unit, .i_pulse_unit, .i_with_temp, .i_count_two_bytes,
        .i_pps_pin, .i_pps_filtered, .i_trim_mode, .i_service_mode, .i_bias_load, .i_bias_axis,
        .i_bias_value, .o_byte, .o_byte_last, .o_byte_valid, .i_byte_ready);
    host_sink host_u (.i_clock, .i_nrst, .i_byte(o_byte), .i_byte_last(o_byte_last), .i_byte_valid(o_byte_valid),
        .o_byte_ready(i_byte_ready));

    // A 50 ns clock.
    initial begin
        i_clock = 1'b0;
        forever #25 i_clock = ~i_clock;
    end

    task check(input logic [8:0] got, input logic [8:0] want);
        total_checks++;
        if (got !== want) begin
            n_fail++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, want);
        end
    endtask : check

    // Queues the low n bytes of v, high byte first.
    task put(input logic [23:0] v, input int n);
        for (int b = n - 1; b >= 0; b--) exp_q.push_back(v[b*8+:8]);
    endtask : put

    // The model only keeps a load that was issued inside one of the adjustment modes.
    task load(input logic [2:0] ax, input logic [23:0] v, input logic tm, input logic sm);
        @(negedge i_clock);
        {i_bias_axis, i_bias_value, i_trim_mode, i_service_mode, i_bias_load} = {ax, v, tm, sm, 1'b1};
        @(negedge i_clock);
        {i_trim_mode, i_service_mode, i_bias_load} = 3'h0;
        if (tm || sm) bias[ax] = v;
    endtask : load

    task frame(input logic [1:0] au, input logic [1:0] pu, input logic wt, input logic two);
        logic [23:0] t;
        logic [23:0] inc;
        longint s;
        int w;
        exp_q.delete();
        host_u.rx_q.delete();
        @(negedge i_clock);
        w = 0;
        while (o_sample_ready !== 1'b1 && w < 100) begin
            @(negedge i_clock);
            w++;
        end
        for (int k = 0; k < 6; k++) i_comp_data[k*24+:24] = 24'($random(seed));
        for (int k = 0; k < 6; k++) i_temp[k*16+:16] = 16'($random(seed));
        {i_latency, i_pps_filtered, i_pps_pin} = {16'($random(seed)), 24'($random(seed)), 1'($random(seed))};
        {i_accel_unit, i_pulse_unit, i_with_temp, i_count_two_bytes, i_sample_valid} = {au, pu, wt, two, 1'b1};
        @(negedge i_clock);
        i_sample_valid = 1'b0;
        // Expected frame: gyros from axis 2 down, accel from axis 3 up in the chosen unit, pulse,
        // counter, latency, then temperatures from axis 5 down, as the sequencer packs them.
        for (int j = 0; j < 6; j++) begin
            int k;
            k = (j < 3) ? 2 - j : j;
            t = i_comp_data[k*24+:24] + bias[k];
            if (k < 3) begin
                put(t, 3);
            end else begin
                s = (longint'($signed(t)) * VS) >>> 16;
                inc = s[23:0];
                acc[k-3] = acc[k-3] + inc;
                put(au == 2'h0 ? t : (au == 2'h1 ? inc : acc[k-3]), 3);
            end
        end
        t = i_pps_filtered[23] ? 24'h000000 : (i_pps_filtered > 24'h400000 ? 24'h400000 : i_pps_filtered);
        put(t, 3);
        put({8'h00, cnt}, two ? 2 : 1);
        cnt++;
        put({8'h00, i_latency}, 2);
        for (int k = 5; k >= 0; k--) if (wt) put({8'h00, i_temp[k*16+:16]}, 2);
        w = 0;
        while (host_u.rx_q.size() < exp_q.size() && w < 500) begin
            @(negedge i_clock);
            w++;
        end
        repeat (3) @(negedge i_clock);
        check(9'(host_u.rx_q.size()), 9'(exp_q.size()));
        for (int b = 0; b < exp_q.size(); b++) begin
            if (pu == 2'h2 || b < 18 || b > 20) begin
                check(host_u.rx_q[b], {b == exp_q.size() - 1, exp_q[b]});
            end
        end
    endtask : frame

    task summarize();
        $display("checks %0d, mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : summarize

    // Watchdog, well beyond twelve stalled frames.
    initial begin
        #2000000;
        n_fail++;
        summarize();
    end

    initial begin
        {i_sample_valid, i_with_temp, i_count_two_bytes, i_pps_pin, i_trim_mode, i_service_mode} = 6'h00;
        {i_comp_data, i_temp, i_latency, i_accel_unit, i_pulse_unit} = '0;
        {i_pps_filtered, i_bias_value, i_bias_axis, i_bias_load, i_nrst} = '0;
        for (int k = 0; k < 6; k++) bias[k] = 24'h000000;
        for (int k = 0; k < 3; k++) acc[k] = 24'h000000;
        cnt = 16'h0000;
        repeat (4) @(posedge i_clock);
        @(negedge i_clock);
        i_nrst = 1'b1;
        for (int k = 0; k < 6; k++) load(3'(k), 24'($random(seed)), k[0], !k[0]);
        load(3'h0, 24'h123456, 1'b0, 1'b0);
        for (int i = 0; i < 12; i++) begin
            frame(2'(i % 3), 2'((i / 3) % 3), i[0], i[1]);
            if (i == 5) load(3'h4, 24'hFFF000, 1'b1, 1'b0);
            $display("test %0d done", i);
        end
        summarize();
    end
endmodule : imu_datagram_field_formatter_tb
